// ---- core/cfdh_locator.sv ----
// Host-side fault locator: drives four switch inputs and reads the shared fault flag.
// Assumes fault_flag_pin is synchronous to sys_clk with its pull-up resolved outside.
`timescale 1ns/100ps
module cfdh_locator
  import cfdh_pkg::*;
#(
  parameter int NCH = CFDH_NCH,
  parameter int SETTLE_CYC = CFDH_SETTLE_CYC,
  parameter int SPACE_CYC = CFDH_SPACE_CYC,
  parameter int LISTEN_CYC = CFDH_LISTEN_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] chan_request,
  input wire logic auto_isolate,
  input wire logic fault_flag_pin,
  output logic [3:0] chan_in,
  output cfdh_result_t result
);
  typedef enum logic [2:0] {
    CFDH_IDLE, CFDH_SETTLE, CFDH_PICK, CFDH_PROBE, CFDH_LISTEN, CFDH_GAP
  } cfdh_state_t;

  cfdh_state_t state, next_state;
  logic [CFDH_CNT_W-1:0] cnt, next_cnt;
  logic [CFDH_CNT_W-1:0] since, next_since;
  logic [1:0] ch, next_ch;
  logic [3:0] tried, next_tried;
  logic [3:0] isolated, next_isolated;
  logic [3:0] next_chan_in;
  cfdh_result_t next_result;
  logic heard, next_heard;

  function automatic logic [1:0] first_set(input logic [3:0] v);
    first_set = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 2'(i);
      end
    end
  endfunction

  wire logic [3:0] active = chan_request & ~isolated;
  wire logic [3:0] pending = active & ~tried;

  always_comb begin
    next_state = state;
    next_cnt = (cnt == '0) ? cnt : cnt - 16'h1;
    next_since = (since == 16'hffff) ? since : since + 16'h1;
    next_ch = ch;
    next_tried = tried;
    next_isolated = isolated & chan_request;
    next_result = result;
    next_heard = heard;
    next_result.busy = (state != CFDH_IDLE);
    unique case (state)
      CFDH_IDLE: begin
        // Low flag with an active channel means a fault somewhere
        if (!fault_flag_pin && (active != 4'h0)) begin
          next_state = CFDH_SETTLE;
          next_cnt = CFDH_CNT_W'(SETTLE_CYC);
        end
      end
      CFDH_SETTLE: begin
        // Wait out flag settle time before probing
        if (fault_flag_pin) begin
          next_state = CFDH_IDLE;
        end else if (cnt == '0) begin
          next_tried = 4'h0;
          next_result.found = 1'b0;
          next_result.none = 1'b0;
          next_state = CFDH_PICK;
        end
      end
      CFDH_PICK: begin
        if (pending == 4'h0) begin
          // No channel answered
          next_result.none = 1'b1;
          next_state = CFDH_GAP;
          next_cnt = CFDH_CNT_W'(SPACE_CYC);
        end else if (since >= CFDH_CNT_W'(SPACE_CYC)) begin
          // One channel at a time, starts 200 us apart
          next_ch = first_set(pending);
          next_tried[first_set(pending)] = 1'b1;
          next_since = '0;
          next_cnt = CFDH_CNT_W'(CFDH_PROBE_CYC);
          next_state = CFDH_PROBE;
        end
      end
      CFDH_PROBE: begin
        // Low pulse of 4 us, inside 3 to 6 us
        if (cnt == 16'h1) begin
          next_cnt = CFDH_CNT_W'(LISTEN_CYC);
          next_heard = 1'b0;
          next_state = CFDH_LISTEN;
        end
      end
      CFDH_LISTEN: begin
        // Window opens about 8 us after the probe
        if (fault_flag_pin) begin
          next_heard = 1'b1;
        end
        if (cnt == '0) begin
          if (heard || fault_flag_pin) begin
            next_result.found = 1'b1;
            next_result.channel = ch;
            // Drop faulty channel input if asked
            if (auto_isolate) begin
              next_isolated[ch] = 1'b1;
            end
            next_state = CFDH_GAP;
            next_cnt = CFDH_CNT_W'(SPACE_CYC);
          end else begin
            next_state = CFDH_PICK;
          end
        end
      end
      CFDH_GAP: begin
        if (cnt == '0) begin
          next_state = CFDH_IDLE;
        end
      end
    endcase
    next_chan_in = chan_request & ~next_isolated;
    if (next_state == CFDH_PROBE) begin
      next_chan_in[next_ch] = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= CFDH_IDLE;
      cnt <= '0;
      since <= 16'hffff;
      ch <= CFDH_CH_RST;
      tried <= 4'h0;
      isolated <= 4'h0;
      chan_in <= 4'h0;
      result <= '0;
      heard <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      since <= next_since;
      ch <= next_ch;
      tried <= next_tried;
      isolated <= next_isolated;
      chan_in <= next_chan_in;
      result <= next_result;
      heard <= next_heard;
    end
  end

  // Run lengths for the timing checks; long spans are counted, not unrolled
  logic [CFDH_CNT_W-1:0] low_run, next_low_run;
  logic [CFDH_CNT_W-1:0] settle_run, next_settle_run;
  logic [CFDH_CNT_W-1:0] listen_run, next_listen_run;

  always_comb begin
    next_low_run = '0;
    next_settle_run = '0;
    next_listen_run = '0;
    if (state == CFDH_PROBE && chan_in != active) begin
      next_low_run = low_run + 16'h1;
    end
    if (state == CFDH_SETTLE) begin
      next_settle_run = settle_run + 16'h1;
    end
    if (state == CFDH_LISTEN) begin
      next_listen_run = listen_run + 16'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      low_run <= '0;
      settle_run <= '0;
      listen_run <= '0;
    end else begin
      low_run <= next_low_run;
      settle_run <= next_settle_run;
      listen_run <= next_listen_run;
    end
  end

  a_probe_width_max: assert property (@(posedge sys_clk) disable iff (rst)
    low_run <= CFDH_CNT_W'(CFDH_PROBE_MAX_US * CFDH_CYC_PER_US))
    else $error("probe pulse too long");
  a_probe_width_min: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(state == CFDH_PROBE) |-> low_run >= CFDH_CNT_W'(CFDH_PROBE_MIN_US * CFDH_CYC_PER_US))
    else $error("probe pulse too short");
  a_probe_restore: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(state == CFDH_PROBE) |-> chan_in == $past(active))
    else $error("probed input not restored");
  a_probe_spacing: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(state == CFDH_PROBE) |-> $past(since) >= CFDH_CNT_W'(CFDH_SPACE_CYC))
    else $error("probe restart too soon");
  a_one_probe: assert property (@(posedge sys_clk) disable iff (rst)
    (state == CFDH_PROBE) |-> $onehot(chan_request & ~isolated & ~chan_in))
    else $error("more than one channel probed");
  a_isolate_only: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(|isolated) |-> result.found && auto_isolate)
    else $error("channel dropped without a find");
  a_found_listened: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(result.found) |-> $past(state) == CFDH_LISTEN)
    else $error("find outside listen window");
  a_follow_request: assert property (@(posedge sys_clk) disable iff (rst)
    (state == CFDH_IDLE) |-> ##1 ((chan_in & ~$past(chan_request)) == 4'h0))
    else $error("input driven without request");
  a_settle_first: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(state == CFDH_SETTLE) |-> (state != CFDH_PROBE) [*8])
    else $error("probe without settle");
  // Start-up into a short may take the whole settle time to pull the flag
  a_settle_long: assert property (@(posedge sys_clk) disable iff (rst)
    (state == CFDH_SETTLE && next_state == CFDH_PICK) |-> settle_run >= CFDH_CNT_W'(SETTLE_CYC))
    else $error("settle wait cut short");
  // Shortest listen that still overlaps the shortest window after its delay
  a_listen_span: assert property (@(posedge sys_clk) disable iff (rst)
    (state == CFDH_LISTEN && next_state != CFDH_LISTEN) |->
    listen_run >= CFDH_CNT_W'((CFDH_DELAY_US + CFDH_WIN_MIN_US) * CFDH_CYC_PER_US))
    else $error("listen window too short");

  c_probe: cover property (@(posedge sys_clk) $rose(state == CFDH_PROBE));
  c_found: cover property (@(posedge sys_clk) $rose(result.found));
  c_none: cover property (@(posedge sys_clk) $rose(result.none));
  c_isolate: cover property (@(posedge sys_clk) $rose(|isolated));
  c_abort: cover property (@(posedge sys_clk) state == CFDH_SETTLE && fault_flag_pin);
endmodule

// ---- include/cfdh_pkg.sv ----
// Constants and types for the host-side fault locator of a four-channel switch.
// Assumes the switch inputs are driven by this block and the shared fault flag is sampled here.
// Overview of operation
// - Host probes each active channel input with one low pulse in turn.
// - Probe pulse lasts between 3 and 6 us.
// - Flag high window starts about 8 us after probe; host waits.
// - Probe starts are spaced at least 200 us apart.
// - Faulty channel is the one whose probe shows the high window.
// - Host may switch the identified faulty channel off.
package cfdh_pkg;
  localparam int CFDH_CLK_HZ = 10_000_000;
  localparam int CFDH_NCH = 4;
  localparam int CFDH_PROBE_US = 4;
  localparam int CFDH_PROBE_MIN_US = 3;
  localparam int CFDH_PROBE_MAX_US = 6;
  localparam int CFDH_DELAY_US = 8;
  localparam int CFDH_WIN_MIN_US = 40;
  localparam int CFDH_WIN_MAX_US = 150;
  localparam int CFDH_SPACE_US = 200;
  localparam int CFDH_SETTLE_US = 90;
  localparam int CFDH_CYC_PER_US = CFDH_CLK_HZ / 1_000_000;
  localparam int CFDH_PROBE_CYC = CFDH_PROBE_US * CFDH_CYC_PER_US;
  // Listen from the probe's rising edge to its latest possible window end
  localparam int CFDH_LISTEN_CYC = (CFDH_DELAY_US + CFDH_WIN_MAX_US) * CFDH_CYC_PER_US;
  localparam int CFDH_SPACE_CYC = CFDH_SPACE_US * CFDH_CYC_PER_US;
  localparam int CFDH_SETTLE_CYC = CFDH_SETTLE_US * CFDH_CYC_PER_US;
  localparam int CFDH_CNT_W = 16;
  localparam logic [1:0] CFDH_CH_RST = 2'h0;
  typedef struct packed {
    logic busy;
    logic found;
    logic none;
    logic [1:0] channel;
  } cfdh_result_t;
endpackage

// ---- testbench/cfdh_switch_model.sv ----
// Behavioural four-channel switch with shared open-drain fault flag.
// Assumes inputs change just after sys_clk edges; shorts injected per channel.
`timescale 1ns/100ps
module cfdh_switch_model #(
  parameter int SETTLE = 300,
  parameter int DELAY = 80,
  parameter int WIN = 400
) (
  input wire logic sys_clk,
  input wire logic [3:0] chan_in,
  input wire logic [3:0] short_gnd,
  input wire logic [3:0] over_temp,
  output logic [3:0] chan_out,
  output logic fault_flag_pin
);
  int low_cnt[4] = '{0, 0, 0, 0};
  int flt_cnt[4] = '{0, 0, 0, 0};
  int win_cnt = 0;
  logic [3:0] bad = 4'h0;
  logic pull_low = 1'b0;
  initial chan_out = 4'h0;
  always @(posedge sys_clk) begin
    for (int i = 0; i < 4; i++) begin
      low_cnt[i] = chan_in[i] ? 0 : low_cnt[i] + 1;
      // Short inversions ignored, output only on or off
      // Hot channel off while cooling, back on after
      chan_out[i] <= !over_temp[i] && (chan_in[i] || (chan_out[i] && (low_cnt[i] < 60)));
      // Shorted output stays on; same settle on start-up into a short
      flt_cnt[i] = ((short_gnd[i] && chan_out[i]) || (over_temp[i] && chan_in[i])) ?
        flt_cnt[i] + 1 : 0;
      bad[i] = flt_cnt[i] > SETTLE;
      if (bad[i] && low_cnt[i] == 1) win_cnt = 1;
    end
    if (win_cnt > 0) win_cnt++;
    if (win_cnt > DELAY + WIN) win_cnt = 0;
    pull_low <= (|bad) && !(win_cnt > DELAY);
  end
  // Released flag reads high through the pull-up
  assign fault_flag_pin = pull_low ? 1'b0 : 1'b1;
endmodule

// ---- testbench/tb_cfdh_locator.sv ----
// Self-checking bench for the fault locator against a switch model.
// Assumes default design counts; run stays under the cycle ceiling.
`timescale 1ns/100ps
module tb_cfdh_locator;
  import cfdh_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] chan_request = 4'h0;
  logic auto_isolate = 1'b1;
  logic [3:0] short_gnd = 4'h0;
  logic [3:0] over_temp = 4'h0;
  logic [3:0] req_q = 4'h0;
  logic fault_flag_pin;
  logic [3:0] chan_in, chan_out;
  cfdh_result_t result;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  int low_w = 0;
  cfdh_locator i_cfdh_locator (.sys_clk(sys_clk), .rst(rst), .chan_request(chan_request),
    .auto_isolate(auto_isolate), .fault_flag_pin(fault_flag_pin), .chan_in(chan_in),
    .result(result));
  cfdh_switch_model i_cfdh_switch_model (.sys_clk(sys_clk), .chan_in(chan_in),
    .short_gnd(short_gnd), .over_temp(over_temp), .chan_out(chan_out),
    .fault_flag_pin(fault_flag_pin));
  always #50 sys_clk = ~sys_clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #10;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 80000) begin
      error_cnt++;
      final_report();
    end
  end
  // Probe width, sampled mid-cycle; the request lag after a change is not a probe
  always @(negedge sys_clk) begin
    if (!rst && req_q == 4'hf && chan_request == 4'hf && chan_in != 4'hf && !result.found) low_w++;
    else if (low_w > 0) begin
      chk(8'(low_w), 8'(CFDH_PROBE_CYC));
      low_w = 0;
    end
    req_q = chan_request;
  end
  task automatic t_normal();
    chan_request = 4'hb;
    step(100);
    chk({4'h0, chan_in}, 8'h0b);
    chk({4'h0, chan_out}, 8'h0b);
    chk({7'h0, fault_flag_pin}, 8'h01);
  endtask
  task automatic t_abort();
    chan_request = 4'hf;
    short_gnd = 4'h2;
    step(400);
    short_gnd = 4'h0;
    step(1500);
    chk({6'h0, result.found, result.none}, 8'h00);
  endtask
  task automatic t_locate(input int ch);
    int n;
    short_gnd = 4'h0;
    short_gnd[ch] = 1'b1;
    n = 0;
    while (!result.busy && n < 3000) begin
      step(1);
      n++;
    end
    while (result.busy && n < 20000) begin
      if (!result.found) chk({4'h0, chan_out}, 8'h0f);
      step(1);
      n++;
    end
    chk({6'h0, result.found, result.none}, 8'h02);
    chk({6'h0, result.channel}, 8'(ch));
    chk({7'h0, chan_in[ch]}, 8'h00);
    chk({7'h0, fault_flag_pin}, 8'h01);
    short_gnd = 4'h0;
    chan_request = 4'h0;
    step(5);
    chan_request = 4'hf;
    step(5);
  endtask
  // Short leaves channel 1 after channel 0's listen, lands on 0: no probe answers
  task automatic t_none();
    int n;
    auto_isolate = 1'b0;
    short_gnd = 4'h2;
    n = 0;
    while (chan_in[0] && n < 3000) begin
      step(1);
      n++;
    end
    step(1650);
    short_gnd = 4'h1;
    n = 0;
    while (!result.none && n < 10000) begin
      step(1);
      n++;
    end
    chk({6'h0, result.found, result.none}, 8'h01);
    while (!result.found && n < 20000) begin
      step(1);
      n++;
    end
    chk({6'h0, result.channel}, 8'h00);
    chk({7'h0, chan_in[0]}, 8'h01);
    short_gnd = 4'h0;
    auto_isolate = 1'b1;
    step(2500);
  endtask
  task automatic t_cool();
    over_temp = 4'h4;
    step(400);
    chk({4'h0, chan_out}, 8'h0b);
    chk({7'h0, fault_flag_pin}, 8'h00);
    over_temp = 4'h0;
    step(1500);
    chk({4'h0, chan_out}, 8'h0f);
    chk({7'h0, result.busy}, 8'h00);
  endtask
  initial begin
    step(6);
    rst = 1'b0;
    step(2);
    t_normal();
    t_abort();
    for (int ch = 0; ch < 4; ch++) t_locate(ch);
    t_none();
    t_cool();
    final_report();
  end
endmodule
